// file: bench/i2c_serial_engine_control_tb_top.sv
// Self-checking bench for the serial engine control block.
// Assumes the engine sits on a wired bus with one target peer.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin \
  fail_count++; $display("[FAIL] %s exp %0h seen %0h", n, e, g); end end
module i2c_serial_engine_control_tb_top;
  logic       clk = 1'b0, rst_n = 1'b0, sfr_wr = 1'b0, isr_active = 1'b0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, tx_byte = 8'hA0;
  logic [7:0] stretch = 8'h00, sfr_rdata, rx_byte;
  logic       byte_done, ack_seen_n, master_mode, tx_mode, bus_busy;
  logic       arb_lost, sda_o, scl_o;
  logic       sda_oe, scl_oe, p_sda_oe, p_scl_oe, mack, scl_q, sda_q;
  wire logic  sda_w = !(sda_oe || p_sda_oe);
  wire logic  scl_w = !(scl_oe || p_scl_oe);
  int checked = 0, fail_count = 0, starts = 0, stops = 0, cnt = 0;
  int per = 0, hi_len = 0, mark, ms, c, i;
  int rt[8] = '{32, 48, 60, 120, 240, 480, 960, 1920};
  always #4 clk = ~clk;
  ise_engine dut_u (.clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .isr_active(isr_active), .tx_byte(tx_byte), .own_slave_id(7'h11),
    .rx_byte(rx_byte), .byte_done(byte_done), .ack_seen_n(ack_seen_n),
    .master_mode(master_mode), .tx_mode(tx_mode), .bus_busy(bus_busy),
    .arb_lost(arb_lost), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
    .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe));
  ise_bus_peer #(.ADDR(7'h50)) peer_u (.clk(clk), .rst_n(rst_n),
    .sda(sda_w), .scl(scl_w), .stretch(stretch), .txd(8'h5A),
    .sda_oe(p_sda_oe), .scl_oe(p_scl_oe), .mack(mack));
  ////////////////////////////////////////////////////////////////////////
  // Bus monitor: conditions, clock period and high time.
  always @(posedge clk) begin
    scl_q <= scl_w;
    sda_q <= sda_w;
    if (scl_w && scl_q && sda_q && !sda_w) starts <= starts + 1;
    if (scl_w && scl_q && !sda_q && sda_w) stops <= stops + 1;
    if (scl_w && !scl_q) begin
      per <= cnt;
      cnt <= 1;
    end else cnt <= cnt + 1;
    if (!scl_w && scl_q) hi_len <= cnt;
  end
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] ctl(input logic [2:0] k,
                                     input logic en, b, e, ak);
    return {k[2], en, b, e, 1'b0, ak, k[1:0]};
  endfunction
  function automatic logic hi_ok(input int h);
    return hi_len >= h - 2 && hi_len <= h + 2;
  endfunction
  task automatic results();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
    // Let an edge pass so a following write never re-raises the strobe.
    @(negedge clk);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    sfr_addr = a;
    repeat (2) @(negedge clk);
    `CHK("rdata", e, sfr_rdata)
  endtask
  // Kind 0 waits for a START, 1 for a byte end, 2 for a free bus.
  task automatic wait_for(input int k);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
      if (n > 40000) begin
        fail_count++;
        $display("[FAIL] wait kind %0d timed out", k);
        results();
      end
    end while (!((k == 0 && starts != mark) || (k == 1 && byte_done === 1'b1)
                 || (k == 2 && bus_busy === 1'b0)));
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    rd_chk(8'hDC, 8'h00);
    `CHK("master", 1'b1, master_mode)
    `CHK("tx after reset", 1'b0, tx_mode)
    `CHK("lines", 2'b00, {sda_oe, scl_oe})
    wr(8'hDC, 8'h8F);
    wr(8'hDD, 8'h55);
    rd_chk(8'hDC, 8'h8F);
    rd_chk(8'hDD, 8'h00);
    for (i = 0; i < 100; i++) begin
      @(negedge clk);
      `CHK("released", 2'b00, {sda_oe, scl_oe})
    end
    $display("test registers done");
    isr_active = 1'b1;
    mark = starts;
    ms = stops;
    wr(8'hDC, ctl(3'h0, 1, 1, 0, 0));
    repeat (300) @(negedge clk);
    `CHK("held start", mark, starts)
    isr_active = 1'b0;
    wait_for(0);
    repeat (4) @(negedge clk);
    rd_chk(8'hDC, ctl(3'h0, 1, 0, 0, 0));
    `CHK("busy", 1'b1, bus_busy)
    isr_active = 1'b1;
    wr(8'hDC, ctl(3'h0, 1, 0, 1, 0));
    wait_for(1);
    `CHK("addr ack", 1'b0, ack_seen_n)
    repeat (40) @(negedge clk);
    `CHK("held stop", 1'b1, bus_busy)
    `CHK("no stop", ms, stops)
    isr_active = 1'b0;
    wait_for(1);
    wait_for(2);
    `CHK("stop", ms + 1, stops)
    $display("test deferral done");
    // At 125 MHz the divide-by-32 setting is within range.
    for (c = 0; c < 8; c++) begin
      mark = starts;
      ms = stops;
      wr(8'hDC, ctl(c[2:0], 1, 1, 0, 0));
      wait_for(0);
      wr(8'hDC, ctl(c[2:0], 1, 0, 1, 0));
      wait_for(1);
      `CHK("ack", 1'b0, ack_seen_n)
      `CHK("period", rt[c], per)
      `CHK("high", 1'b1, hi_ok(rt[c] / 2))
      wait_for(2);
      `CHK("stop", ms + 1, stops)
      rd_chk(8'hDC, ctl(c[2:0], 1, 0, 0, 0));
    end
    $display("test rates done");
    stretch = 8'd20;
    tx_byte = 8'hA1;
    mark = starts;
    wr(8'hDC, ctl(3'h0, 1, 1, 0, 1));
    wait_for(0);
    wait_for(1);
    `CHK("addr ack", 1'b0, ack_seen_n)
    wait_for(1);
    `CHK("rx", 8'h5A, rx_byte)
    `CHK("master ack", 1'b0, mack)
    `CHK("receive", 1'b0, tx_mode)
    `CHK("high", 1'b1, hi_ok(16))
    wr(8'hDC, ctl(3'h0, 1, 0, 1, 0));
    wait_for(1);
    `CHK("master nack", 1'b1, mack)
    wait_for(2);
    $display("test read done");
    stretch = 8'h00;
    tx_byte = 8'hA0;
    mark = starts;
    ms = stops;
    wr(8'hDC, ctl(3'h0, 1, 1, 0, 0));
    wait_for(0);
    mark = starts;
    wr(8'hDC, ctl(3'h0, 1, 1, 0, 0));
    wait_for(0);
    `CHK("restart", ms, stops)
    wr(8'hDC, ctl(3'h0, 1, 0, 1, 0));
    wait_for(1);
    `CHK("restart ack", 1'b0, ack_seen_n)
    wait_for(2);
    `CHK("restart stop", ms + 1, stops)
    `CHK("master kept", 2'b10, {master_mode, arb_lost})
    `CHK("pin data", 2'b00, {sda_o, scl_o})
    $display("test restart done");
    results();
  end
endmodule
`default_nettype wire

// file: bench/ise_bus_peer.sv
// Behavioural target on the two-wire bus: acks its address, serves reads.
// Assumes wired levels with pull-ups on sda and scl, sampled on clk.
`timescale 1ns/1ps
`default_nettype none
module ise_bus_peer #(
  parameter logic [6:0] ADDR = 7'h50
) (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Wired bus levels.
  input  wire logic       sda,
  input  wire logic       scl,
  // Behaviour knobs.
  input  wire logic [7:0] stretch,
  input  wire logic [7:0] txd,
  // Pull-down enables and the master's last acknowledge.
  output logic            sda_oe,
  output logic            scl_oe,
  output logic            mack
);
  logic       scl_q, sda_q, act, first, rd;
  logic [3:0] bitc;
  logic [7:0] sh, hold;
  always_ff @(posedge clk) begin
    scl_q <= scl;
    sda_q <= sda;
    if (!rst_n) begin
      {act, first, rd, sda_oe, scl_oe, mack} <= '0;
      bitc <= 4'h0;
      hold <= 8'h00;
    end else begin
      if (hold != 8'h00) hold <= hold - 8'h01;
      else scl_oe <= 1'b0;
      if (scl && scl_q && sda_q && !sda) begin
        {act, first, rd, sda_oe} <= 4'b1100;
        bitc <= 4'hF;
      end else if (scl && scl_q && !sda_q && sda) begin
        {act, rd, sda_oe} <= 3'b000;
      end else if (act && scl && !scl_q) begin
        if (bitc < 4'h8) sh <= {sh[6:0], sda};
        else mack <= sda;
      end else if (act && scl_q && !scl) begin
        // A nonzero stretch holds the clock low after every fall.
        if (stretch != 8'h00) begin
          scl_oe <= 1'b1;
          hold <= stretch;
        end
        if (bitc == 4'h7) begin
          bitc <= 4'h8;
          if (first) begin
            rd <= sh[0] && sh[7:1] == ADDR;
            act <= sh[7:1] == ADDR;
            sda_oe <= sh[7:1] == ADDR;
          end else sda_oe <= !rd;
        end else if (bitc == 4'h8) begin
          bitc <= 4'h0;
          first <= 1'b0;
          if (!first && mack) rd <= 1'b0;
          sda_oe <= rd && !(!first && mack) && !txd[7];
        end else begin
          bitc <= bitc + 4'h1;
          sda_oe <= rd && !first && !txd[3'(4'h6 - bitc)];
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: rtl/ise_engine.sv
// Control part of the two-wire serial engine: control register, master
// start/byte/stop sequencing, clock generation and acknowledge return.
// Assumes bus inputs are already synchronous to clk and that the wired
// level of each open-drain line is built outside from the enables.
//
// Contract
// R01 - Clearing the enable bit disables the engine and releases both lines.
// R02 - Setting the begin bit enters master mode and sends START once idle.
// R03 - The begin bit clears itself when a START is seen on the bus.
// R04 - A begin request made during interrupt service waits for its end.
// R05 - Setting the end bit in master mode sends a STOP condition.
// R06 - The end bit clears itself when a STOP is seen on the bus.
// R07 - An end request made during interrupt service waits for its end.
// R08 - With ack enable set, data is pulled low in each acknowledge slot; the code does so only as master receiver or as addressed slave.
// R09 - With ack enable clear, data is left high in the acknowledge slot.
// R10 - In master mode the three rate bits divide the clock by 32 to 1920.
// R11 - Software must not pick divide-by-32 at 36 or 40 MHz oscillators.
// R12 - The control register reads back what was written and resets to 0.
// R13 - After reset the engine is a master receiver with both lines released.
// R14 - START and STOP are data edges with clock high; else data moves low.
// R15 - Each byte is followed by a ninth acknowledge bit time.
// R16 - The clock high phase waits until the sensed clock line is high.
`timescale 1ns/1ps
`default_nettype none
module ise_engine
  import ise_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Special function register port.
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  // Interrupt service in progress.
  input  wire logic       isr_active,
  // Byte path to the data shift register.
  input  wire logic [7:0] tx_byte,
  input  wire logic [6:0] own_slave_id,
  output logic      [7:0] rx_byte,
  output logic            byte_done,
  output logic            ack_seen_n,
  // Mode status.
  output logic            master_mode,
  output logic            tx_mode,
  output logic            bus_busy,
  output logic            arb_lost,
  // Open-drain bus lines.
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  input  wire logic       scl_i,
  output logic            scl_o,
  output logic            scl_oe
);

  logic [7:0] ctrl_reg;
  ise_state_e state_reg;
  logic [1:0] ph_reg;
  logic [3:0] bit_reg;
  logic [7:0] shift_reg;
  logic       rx_mode_reg;
  logic       addr_byte_reg;
  logic       m_sda_low_reg;
  logic       m_scl_low_reg;
  logic       sda_prev_reg;
  logic       scl_prev_reg;
  logic [3:0] s_cnt_reg;
  logic [7:0] s_shift_reg;
  logic       s_addr_reg;
  logic       s_sel_reg;
  logic       s_ack_low_reg;
  logic       tick;
  logic       wr_ctrl;
  logic       en;
  logic       start_det;
  logic       stop_det;
  logic       scl_rise;
  logic       scl_fall;
  logic       hold;
  logic       ack_en;
  logic       end_go;
  logic       begin_go;

  assign wr_ctrl   = sfr_wr && (sfr_addr == ISE_CTRL_OFFSET);
  assign en        = ctrl_reg[ISE_ENABLE_POS];
  assign ack_en    = ctrl_reg[ISE_ACK_POS];
  assign start_det = scl_i && scl_prev_reg && sda_prev_reg && !sda_i; // [R14]
  assign stop_det  = scl_i && scl_prev_reg && !sda_prev_reg && sda_i; // [R14]
  assign scl_rise  = !scl_prev_reg && scl_i;
  assign scl_fall  = scl_prev_reg && !scl_i;
  // Requests made inside interrupt service are deferred until it ends.
  assign end_go    = ctrl_reg[ISE_END_POS] && !isr_active;   // [R07]
  assign begin_go  = ctrl_reg[ISE_BEGIN_POS] && !isr_active; // [R04]
  // Our own release must reach the pin first, or each bit gains a cycle.
  assign hold      = (state_reg != ISE_ST_IDLE) && !m_scl_low_reg &&
                     !scl_oe && !scl_i; // [R16]

  ise_rate_div u_div (
    .clk   (clk),
    .rst_n (rst_n),
    .run   (en && (state_reg != ISE_ST_IDLE) && (state_reg != ISE_ST_LOST)),
    .hold  (hold),
    .code  ({ctrl_reg[ISE_RATE_MSB_POS], ctrl_reg[ISE_RATE_MID_POS],
             ctrl_reg[ISE_RATE_LSB_POS]}),
    .tick  (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Control register. A software write beats a same-cycle hardware clear,
  // so a fresh request is never lost.

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_reg <= ISE_CTRL_RESET; // [R12]
    end else if (wr_ctrl) begin
      ctrl_reg <= sfr_wdata; // [R12]
    end else begin
      if (start_det) begin
        ctrl_reg[ISE_BEGIN_POS] <= 1'b0; // [R03]
      end
      if (stop_det) begin
        ctrl_reg[ISE_END_POS] <= 1'b0; // [R06]
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sfr_rdata <= ISE_READ_IDLE;
    end else if (sfr_addr == ISE_CTRL_OFFSET) begin
      sfr_rdata <= ctrl_reg; // [R12]
    end else begin
      sfr_rdata <= ISE_READ_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus condition tracking.

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sda_prev_reg <= 1'b1;
      scl_prev_reg <= 1'b1;
      bus_busy     <= 1'b0;
    end else begin
      sda_prev_reg <= sda_i;
      scl_prev_reg <= scl_i;
      if (start_det) begin
        bus_busy <= 1'b1;
      end else if (stop_det) begin
        bus_busy <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Master sequencer. Each bit is four quarters: two with the clock held
  // low (data changes in the first), two with it released.

  always_ff @(posedge clk) begin
    if (!rst_n || !en) begin
      state_reg     <= ISE_ST_IDLE; // [R01]
      ph_reg        <= 2'h0;
      bit_reg       <= 4'h0;
      shift_reg     <= 8'h00;
      rx_mode_reg   <= 1'b1; // [R13]
      addr_byte_reg <= 1'b0;
      m_sda_low_reg <= 1'b0;
      m_scl_low_reg <= 1'b0;
      byte_done     <= 1'b0;
      rx_byte       <= 8'h00;
      ack_seen_n    <= 1'b1;
      arb_lost      <= 1'b0;
    end else begin
      byte_done <= 1'b0;
      case (state_reg)
        ISE_ST_IDLE: begin
          m_sda_low_reg <= 1'b0;
          m_scl_low_reg <= 1'b0;
          ph_reg        <= 2'h0;
          if (begin_go && !bus_busy) begin
            state_reg <= ISE_ST_START; // [R02]
            arb_lost  <= 1'b0;
          end
        end
        ISE_ST_START: begin
          if (tick) begin
            ph_reg <= ph_reg + 2'h1;
            if (ph_reg == 2'h0) begin
              m_sda_low_reg <= 1'b1; // [R14]
            end else begin
              m_scl_low_reg <= 1'b1;
              state_reg     <= ISE_ST_BIT;
              ph_reg        <= 2'h0;
              bit_reg       <= 4'h0;
              shift_reg     <= tx_byte;
              addr_byte_reg <= 1'b1;
              rx_mode_reg   <= 1'b0;
            end
          end
        end
        ISE_ST_BIT: begin
          if (tick) begin
            ph_reg <= ph_reg + 2'h1;
            case (ph_reg)
              2'h0: begin
                if (bit_reg == ISE_ACK_INDEX) begin
                  m_sda_low_reg <= rx_mode_reg && ack_en; // [R08] [R09] [R15]
                end else begin
                  m_sda_low_reg <= !rx_mode_reg && !shift_reg[7];
                end
              end
              2'h1: begin
                m_scl_low_reg <= 1'b0;
              end
              2'h2: begin
              end
              2'h3: begin
                m_scl_low_reg <= 1'b1;
                if (bit_reg != ISE_ACK_INDEX) begin
                  shift_reg <= {shift_reg[6:0], sda_i};
                  bit_reg   <= bit_reg + 4'h1;
                  if (!rx_mode_reg && shift_reg[7] && !sda_i) begin
                    // Another master won: drop off the bus at once.
                    state_reg     <= ISE_ST_LOST;
                    m_sda_low_reg <= 1'b0;
                    m_scl_low_reg <= 1'b0;
                    arb_lost      <= 1'b1;
                    byte_done     <= 1'b1;
                  end
                end else begin
                  bit_reg       <= 4'h0;
                  byte_done     <= 1'b1;
                  rx_byte       <= shift_reg;
                  ack_seen_n    <= sda_i;
                  m_sda_low_reg <= 1'b0;
                  if (addr_byte_reg) begin
                    rx_mode_reg <= shift_reg[0];
                  end
                  addr_byte_reg <= 1'b0;
                  if (end_go) begin
                    state_reg <= ISE_ST_STOP; // [R05]
                  end else if (begin_go) begin
                    state_reg <= ISE_ST_RSTART;
                  end else begin
                    shift_reg <= tx_byte;
                  end
                end
              end
              default: begin
              end
            endcase
          end
        end
        ISE_ST_RSTART, ISE_ST_STOP: begin
          if (tick) begin
            ph_reg <= ph_reg + 2'h1;
            case (ph_reg)
              2'h0: m_sda_low_reg <= (state_reg == ISE_ST_STOP);
              2'h1: m_scl_low_reg <= 1'b0;
              2'h2: begin
              end
              default: begin
                // Data edge while the clock is high forms the condition.
                m_sda_low_reg <= (state_reg == ISE_ST_RSTART); // [R14]
                state_reg <= (state_reg == ISE_ST_STOP) ? ISE_ST_IDLE
                                                        : ISE_ST_START;
                ph_reg    <= (state_reg == ISE_ST_STOP) ? 2'h0 : 2'h1;
              end
            endcase
          end
        end
        ISE_ST_LOST: begin
          if (stop_det || !bus_busy) begin
            state_reg <= ISE_ST_IDLE;
          end
        end
        default: begin
          state_reg <= ISE_ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slave receiver acknowledge. Only acts while not running as master.

  always_ff @(posedge clk) begin
    if (!rst_n || !en) begin
      s_cnt_reg     <= 4'h0;
      s_shift_reg   <= 8'h00;
      s_addr_reg    <= 1'b0;
      s_sel_reg     <= 1'b0;
      s_ack_low_reg <= 1'b0;
    end else if (start_det) begin
      s_cnt_reg     <= 4'h0;
      s_addr_reg    <= 1'b1;
      s_sel_reg     <= 1'b0;
      s_ack_low_reg <= 1'b0;
    end else if (stop_det) begin
      s_addr_reg    <= 1'b0;
      s_sel_reg     <= 1'b0;
      s_ack_low_reg <= 1'b0;
    end else if (state_reg == ISE_ST_IDLE || state_reg == ISE_ST_LOST) begin
      if (scl_rise && s_cnt_reg < ISE_ACK_INDEX) begin
        s_shift_reg <= {s_shift_reg[6:0], sda_i};
      end
      if (scl_fall) begin
        if (s_cnt_reg == ISE_ACK_INDEX - 4'h1) begin
          s_cnt_reg <= ISE_ACK_INDEX;
          if (s_addr_reg) begin
            // Only write addresses are taken; reads deselect the slave.
            s_sel_reg <= (s_shift_reg[7:1] == own_slave_id) &&
                         !s_shift_reg[0];
            s_ack_low_reg <= ack_en &&
                             (s_shift_reg[7:1] == own_slave_id); // [R08]
          end else begin
            s_ack_low_reg <= ack_en && s_sel_reg; // [R08] [R09]
          end
        end else if (s_cnt_reg == ISE_ACK_INDEX) begin
          s_cnt_reg     <= 4'h0;
          s_addr_reg    <= 1'b0;
          s_ack_low_reg <= 1'b0; // [R15]
        end else begin
          s_cnt_reg <= s_cnt_reg + 4'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin and status outputs, all registered.

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sda_o       <= 1'b0;
      scl_o       <= 1'b0;
      sda_oe      <= 1'b0; // [R13]
      scl_oe      <= 1'b0; // [R13]
      master_mode <= 1'b1;
      tx_mode     <= 1'b0;
    end else begin
      sda_o       <= 1'b0;
      scl_o       <= 1'b0;
      sda_oe      <= en && (m_sda_low_reg || s_ack_low_reg); // [R01]
      scl_oe      <= en && m_scl_low_reg; // [R01]
      master_mode <= (state_reg != ISE_ST_LOST) && !s_sel_reg;
      tx_mode     <= (state_reg != ISE_ST_IDLE) &&
                     (state_reg != ISE_ST_LOST) && !rx_mode_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_disable_release: assert property (!en |=> !sda_oe && !scl_oe) // [R01]
    else $error("Lines driven while disabled.");
  a_start_enter: assert property (en && state_reg == ISE_ST_IDLE &&
      begin_go && !bus_busy |=> state_reg == ISE_ST_START) // [R02]
    else $error("Begin request did not start master.");
  a_busy_wait: assert property (state_reg == ISE_ST_IDLE && bus_busy
      |=> state_reg != ISE_ST_START) // [R02]
    else $error("START issued on busy bus.");
  a_begin_clear: assert property (start_det && !wr_ctrl
      |=> !ctrl_reg[ISE_BEGIN_POS]) // [R03]
    else $error("Begin bit not cleared on START.");
  a_isr_begin: assert property (state_reg == ISE_ST_IDLE && isr_active
      |=> state_reg != ISE_ST_START) // [R04]
    else $error("START issued during service.");
  a_stop_enter: assert property (en && state_reg == ISE_ST_BIT && tick &&
      ph_reg == ISE_PH_LAST && bit_reg == ISE_ACK_INDEX && end_go
      |=> state_reg == ISE_ST_STOP) // [R05]
    else $error("End request did not stop.");
  a_end_clear: assert property (stop_det && !wr_ctrl
      |=> !ctrl_reg[ISE_END_POS]) // [R06]
    else $error("End bit not cleared on STOP.");
  a_isr_end: assert property (state_reg == ISE_ST_BIT && isr_active
      |=> state_reg != ISE_ST_STOP) // [R07]
    else $error("STOP issued during service.");
  a_slave_ack: assert property (en && $rose(s_ack_low_reg)
      |-> $past(ack_en) ##1 sda_oe) // [R08]
    else $error("Slave acknowledge not driven.");
  a_no_ack: assert property (!ack_en && !wr_ctrl && !s_ack_low_reg
      |=> !s_ack_low_reg) // [R09]
    else $error("Acknowledge given while disabled.");
  a_ctrl_write: assert property (wr_ctrl
      |=> ctrl_reg == $past(sfr_wdata)) // [R12]
    else $error("Control write not stored.");

  c_start: cover property (state_reg == ISE_ST_START ##1
                           state_reg == ISE_ST_BIT);
  c_byte: cover property (byte_done && !arb_lost);
  c_lost: cover property (state_reg == ISE_ST_LOST);
  c_sack: cover property ($rose(s_ack_low_reg));

endmodule
`default_nettype wire

// file: rtl/ise_pkg.sv
// Constants shared by the two-wire serial engine control block.
// Assumes a single 125 MHz clock that also serves as the engine's oscillator.
package ise_pkg;

  // Control register location and reset value.
  localparam logic [7:0] ISE_CTRL_OFFSET = 8'hDC;
  localparam logic [7:0] ISE_CTRL_RESET  = 8'h00;

  // Control register field positions.
  localparam int ISE_RATE_MSB_POS  = 7;
  localparam int ISE_ENABLE_POS    = 6;
  localparam int ISE_BEGIN_POS     = 5;
  localparam int ISE_END_POS       = 4;
  localparam int ISE_ADDR_POS      = 3;
  localparam int ISE_ACK_POS       = 2;
  localparam int ISE_RATE_MID_POS  = 1;
  localparam int ISE_RATE_LSB_POS  = 0;

  // Value read back from any other address.
  localparam logic [7:0] ISE_READ_IDLE = 8'h00;

  // Bit period is cut into four quarter phases.
  localparam int         ISE_QUARTERS  = 4;
  localparam logic [3:0] ISE_ACK_INDEX = 4'h8;
  localparam logic [1:0] ISE_PH_LAST   = 2'h3;

  // Oscillator divide ratios for rate codes 0 to 7.
  localparam logic [11:0] ISE_DIV_RATIO [8] = '{
    12'h020, 12'h030, 12'h03C, 12'h078,
    12'h0F0, 12'h1E0, 12'h3C0, 12'h780
  };

  typedef enum logic [2:0] {
    ISE_ST_IDLE   = 3'b000,
    ISE_ST_START  = 3'b001,
    ISE_ST_BIT    = 3'b010,
    ISE_ST_RSTART = 3'b011,
    ISE_ST_STOP   = 3'b100,
    ISE_ST_LOST   = 3'b101
  } ise_state_e;

  // Clock cycles in one quarter of a bit period for a rate code.
  function automatic logic [9:0] ise_quarter(input logic [2:0] code);
    logic [11:0] r;
    r = ISE_DIV_RATIO[code];
    return r[11:2];
  endfunction

endpackage

// file: rtl/ise_rate_div.sv
// Quarter-bit enable generator for the serial engine master clock.
// Assumes the caller raises hold while the clock line is released but low.
`timescale 1ns/1ps
`default_nettype none
module ise_rate_div
  import ise_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Control.
  input  wire logic       run,
  input  wire logic       hold,
  input  wire logic [2:0] code,
  // Quarter enable pulse.
  output logic            tick
);

  logic [9:0] cnt_reg;

  always_ff @(posedge clk) begin
    if (!rst_n || !run) begin
      cnt_reg <= 10'h000;
      tick    <= 1'b0;
    end else if (hold) begin
      // Another device stretches the clock, so time stands still.
      tick <= 1'b0; // [R16]
    end else if (cnt_reg >= ise_quarter(code) - 10'h001) begin
      cnt_reg <= 10'h000;
      tick    <= 1'b1; // [R10]
    end else begin
      cnt_reg <= cnt_reg + 10'h001;
      tick    <= 1'b0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_quarter_min: assert property (tick |=> !tick [*7]) // [R10]
    else $error("Quarter tick came too early.");
  a_stretch_hold: assert property (hold |=> !tick) // [R16]
    else $error("Tick issued while clock stretched.");

endmodule
`default_nettype wire
